// file: core/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Byte offsets on the register bus
`define OFS_CTRL_TWO      5'h00
`define OFS_CTRL_THREE    5'h04
`define OFS_CTRL_FOUR     5'h08
`define OFS_AUX_SEL       5'h0c
`define OFS_MAIN_SEL      5'h10
`define OFS_MODE          5'h14
`define OFS_SCAN_LIST     5'h18

// Reset values
`define RST_REG16         16'h0000
`define RST_SCAN          32'h0000_0000

// Writable bit masks
`define WMASK_CTRL_TWO    16'he73f
`define WMASK_CTRL_THREE  16'h9fff
`define WMASK_CTRL_FOUR   16'h0007
`define WMASK_AUX_SEL     16'h0707
`define WMASK_MAIN_SEL    16'h9f9f
`define WMASK_MAIN_SEL_LO 16'h8f8f
`define WMASK_MODE        16'h001f

// Control two fields
`define F_REF_SEL_HI      15
`define F_REF_SEL_LO      13
`define F_SCAN_EN         10
`define F_CHAN_CNT_HI     9
`define F_CHAN_CNT_LO     8
`define F_BUF_HALF        7
`define F_OPS_HI          5
`define F_OPS_LO          2
`define F_SPLIT_BUF       1
`define F_ALT_INPUT       0

// Control three fields
`define F_CLK_SRC         15
`define F_SAMP_HI         12
`define F_SAMP_LO         8
`define F_DIV_HI          7
`define F_DIV_LO          0

// Control four field
`define F_DMA_LEN_HI      2
`define F_DMA_LEN_LO      0

// Input select fields
`define F_AUX_NEG_B_HI    10
`define F_AUX_NEG_B_LO    9
`define F_AUX_POS_B       8
`define F_AUX_NEG_A_HI    2
`define F_AUX_NEG_A_LO    1
`define F_AUX_POS_A       0
`define F_MAIN_NEG_B      15
`define F_MAIN_POS_B_HI   12
`define F_MAIN_POS_B_LO   8
`define F_MAIN_NEG_A      7
`define F_MAIN_POS_A_HI   4
`define F_MAIN_POS_A_LO   0

// Mode register fields
`define F_RUN             0
`define F_RES_MODE        1
`define F_TRIG_HI         4
`define F_TRIG_LO         2

// Codes
`define TRIG_AUTO         3'h7
`define NEG_SEL_VREF_HI   1'h0

`endif

// file: core/adc_seq_pkg.sv
package adc_seq_pkg;

    typedef enum logic [0:0] {
        PH_SAMPLE,
        PH_CONVERT
    } phase_t;

    typedef struct packed {
        logic [15:0] ctrl_two;
        logic [15:0] ctrl_three;
        logic [15:0] ctrl_four;
        logic [15:0] aux_sel;
        logic [15:0] main_sel;
        logic [15:0] mode;
        logic [31:0] scan_list;
        logic        waitreq;
        logic [31:0] rdata;
        phase_t      phase;
        logic        set_b;
        logic [4:0]  scan_idx;
        logic [3:0]  op_cnt;
        logic        buf_half;
        logic [7:0]  div_cnt;
        logic [4:0]  samp_cnt;
        logic [2:0]  rc_sync;
        logic [2:0]  done_sync;
        logic        conv_tick;
        logic        start_conv;
        logic        dma_event;
        logic        sampling;
        logic [4:0]  ch0_pos;
        logic        ch0_neg;
        logic        aux_pos;
        logic [1:0]  aux_neg;
        logic        vref_pos_ext;
        logic        vref_neg_ext;
        logic [1:0]  chan_count;
        logic [7:0]  dma_words;
    } state_t;

endpackage

// file: core/adc_seq_ctrl.sv
`include "adc_seq_cfg.svh"

// Contract
// - Reference code picks supply or external per polarity; codes 1xx act as 000.
// - Scan enable steps channel-0 positive input through scan list in first set.
// - Channel count: 00 only channel 0, 01 channels 0-1, 1x all four.
// - In 12-bit mode channel count reads zero and only channel 0 converts.
// - Buffer-half flag reads 1 filling second half, 0 filling first half.
// - Address increment or event after every N-th operation, N is field plus one.
// - Split mode alternates buffer halves per event; otherwise always fill from start.
// - Alternate mode swaps input sets each sample; otherwise always first set.
// - Clock source bit: 1 selects RC oscillator, 0 system-clock derived clock.
// - Auto-sample field sets sampling length, 0 to 31 conversion-clock periods.
// - Auto-sample length used only when trigger source is internal counter.
// - Derived conversion clock period is cycle times divider plus one.
// - Divider ignored while the RC clock source is selected.
// - DMA buffer length per input is two to the power of the code.
// - Aux negative: 11 inputs 9-11, 10 inputs 6-8, 0x negative reference.
// - Aux positive: 1 inputs 3-5, 0 inputs 0-2.
// - Second input set has its own aux selects with identical encodings.
// - In 12-bit mode all aux select fields read zero.
// - Channel-0 negative: 1 input 1, 0 negative reference.
// - Channel-0 positive select connects the input numbered by the code.
// - Second input set has its own channel-0 selects, same encodings.
// - Second converter instance only accepts inputs 0 to 15 on channel 0.
// - Resolution bit: 1 selects 12-bit single channel, 0 10-bit four channel.
// - Trigger code 111 lets the internal counter end sampling and convert.
module adc_seq_ctrl #(
    parameter bit SECOND_INSTANCE = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        rc_clk_pin,
    input  wire logic        conv_done_pin,
    output logic             conv_tick,
    output logic             start_conv,
    output logic             sampling,
    output logic             dma_event,
    output logic             buffer_half_flag,
    output logic [4:0]       ch0_pos_input,
    output logic             ch0_neg_input,
    output logic             aux_pos_input,
    output logic [1:0]       aux_neg_input,
    output logic             vref_pos_external,
    output logic             vref_neg_external,
    output logic [1:0]       channel_count,
    output logic [7:0]       dma_buffer_words
);
    import adc_seq_pkg::*;

    state_t s_r;
    state_t s_nxt;

    // Next selected scan entry after the current one
    function automatic logic [4:0] next_scan(input logic [31:0] list, input logic [4:0] cur);
        logic [4:0] cand;
        logic [4:0] res;
        logic       found;
        res   = cur;
        found = 1'b0;
        for (int i = 1; i <= 32; i++) begin
            cand = cur + 5'(i);
            if (SECOND_INSTANCE)
            begin
                cand[4] = 1'b0;
            end
            if (!found && list[cand])
            begin
                res   = cand;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be, input logic [15:0] wmask);
        logic [15:0] v;
        v = old;
        if (be[0])
        begin
            v[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            v[15:8] = wd[15:8];
        end
        return v & wmask;
    endfunction

    logic        res12;
    logic        auto_trig;
    logic        running;
    logic [2:0]  ref_code;
    logic [1:0]  chan_eff;
    logic [3:0]  ops_field;
    logic [4:0]  samp_len;
    logic [7:0]  div_val;
    logic [15:0] aux_eff;
    logic [15:0] main_wmask;
    logic        rc_edge;
    logic        done_edge;
    logic        tick;
    logic        op_done;
    logic        scan_on;
    logic [31:0] rd_val;

    always_comb
    begin
        s_nxt      = s_r;
        res12      = s_r.mode[`F_RES_MODE];
        auto_trig  = s_r.mode[`F_TRIG_HI:`F_TRIG_LO] == `TRIG_AUTO;
        running    = s_r.mode[`F_RUN];
        ref_code   = s_r.ctrl_two[`F_REF_SEL_HI:`F_REF_SEL_LO];
        chan_eff   = res12 ? 2'h0 : s_r.ctrl_two[`F_CHAN_CNT_HI:`F_CHAN_CNT_LO];
        ops_field  = s_r.ctrl_two[`F_OPS_HI:`F_OPS_LO];
        samp_len   = s_r.ctrl_three[`F_SAMP_HI:`F_SAMP_LO];
        div_val    = s_r.ctrl_three[`F_DIV_HI:`F_DIV_LO];
        aux_eff    = res12 ? 16'h0000 : s_r.aux_sel;
        main_wmask = SECOND_INSTANCE ? `WMASK_MAIN_SEL_LO : `WMASK_MAIN_SEL;
        scan_on    = s_r.ctrl_two[`F_SCAN_EN] && !s_r.set_b;
        rc_edge    = s_r.rc_sync[1] && !s_r.rc_sync[2];
        done_edge  = s_r.done_sync[1] && !s_r.done_sync[2];
        tick       = 1'b0;
        op_done    = 1'b0;
        rd_val     = 32'h0000_0000;

        // Pin synchronisers and edge history
        s_nxt.rc_sync   = {s_r.rc_sync[1:0], rc_clk_pin};
        s_nxt.done_sync = {s_r.done_sync[1:0], conv_done_pin};

        // Bus read mux; unimplemented bits read zero
        case (address)
            `OFS_CTRL_TWO:
            begin
                rd_val[15:0] = s_r.ctrl_two;
                rd_val[`F_CHAN_CNT_HI:`F_CHAN_CNT_LO] = chan_eff;
                rd_val[`F_BUF_HALF] = s_r.buf_half;
            end
            `OFS_CTRL_THREE: rd_val[15:0] = s_r.ctrl_three;
            `OFS_CTRL_FOUR:  rd_val[15:0] = s_r.ctrl_four;
            `OFS_AUX_SEL:    rd_val[15:0] = aux_eff;
            `OFS_MAIN_SEL:   rd_val[15:0] = s_r.main_sel;
            `OFS_MODE:       rd_val[15:0] = s_r.mode;
            `OFS_SCAN_LIST:  rd_val = s_r.scan_list;
            default:         rd_val = 32'h0000_0000;
        endcase

        // Avalon slave: one wait cycle, then complete
        s_nxt.waitreq = 1'b1;
        if ((read || write) && s_r.waitreq)
        begin
            s_nxt.waitreq = 1'b0;
            s_nxt.rdata   = read ? rd_val : 32'h0000_0000;
        end
        if (write && !s_r.waitreq)
        begin
            case (address)
                `OFS_CTRL_TWO:
                    s_nxt.ctrl_two = merge16(s_r.ctrl_two, writedata, byteenable,
                                             `WMASK_CTRL_TWO);
                `OFS_CTRL_THREE:
                    s_nxt.ctrl_three = merge16(s_r.ctrl_three, writedata, byteenable,
                                               `WMASK_CTRL_THREE);
                `OFS_CTRL_FOUR:
                    s_nxt.ctrl_four = merge16(s_r.ctrl_four, writedata, byteenable,
                                              `WMASK_CTRL_FOUR);
                `OFS_AUX_SEL:
                    s_nxt.aux_sel = merge16(s_r.aux_sel, writedata, byteenable,
                                            `WMASK_AUX_SEL);
                `OFS_MAIN_SEL:
                    s_nxt.main_sel = merge16(s_r.main_sel, writedata, byteenable,
                                             main_wmask);
                `OFS_MODE:
                    s_nxt.mode = merge16(s_r.mode, writedata, byteenable, `WMASK_MODE);
                `OFS_SCAN_LIST:
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (byteenable[b])
                        begin
                            s_nxt.scan_list[b*8 +: 8] = writedata[b*8 +: 8];
                        end
                    end
                    if (SECOND_INSTANCE)
                    begin
                        s_nxt.scan_list[31:16] = 16'h0000;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Conversion clock tick
        if (!running)
        begin
            s_nxt.div_cnt = 8'h00;
        end
        else if (s_r.ctrl_three[`F_CLK_SRC])
        begin
            tick          = rc_edge;
            s_nxt.div_cnt = 8'h00;
        end
        else if (s_r.div_cnt >= div_val)
        begin
            tick          = 1'b1;
            s_nxt.div_cnt = 8'h00;
        end
        else
        begin
            s_nxt.div_cnt = s_r.div_cnt + 8'h01;
        end

        // Sample and convert sequencing
        s_nxt.start_conv = 1'b0;
        if (!running)
        begin
            s_nxt.phase    = PH_SAMPLE;
            s_nxt.samp_cnt = 5'h00;
        end
        else
        begin
            case (s_r.phase)
                PH_SAMPLE:
                begin
                    if (auto_trig && tick)
                    begin
                        if (s_r.samp_cnt >= samp_len)
                        begin
                            s_nxt.start_conv = 1'b1;
                            s_nxt.phase      = PH_CONVERT;
                            s_nxt.samp_cnt   = 5'h00;
                        end
                        else
                        begin
                            s_nxt.samp_cnt = s_r.samp_cnt + 5'h01;
                        end
                    end
                    if (done_edge)
                    begin
                        op_done        = 1'b1;
                        s_nxt.samp_cnt = 5'h00;
                    end
                end
                PH_CONVERT:
                begin
                    if (done_edge)
                    begin
                        op_done     = 1'b1;
                        s_nxt.phase = PH_SAMPLE;
                    end
                end
                default: s_nxt.phase = PH_SAMPLE;
            endcase
        end

        // Operation bookkeeping
        s_nxt.dma_event = 1'b0;
        if (op_done)
        begin
            if (s_r.op_cnt >= ops_field)
            begin
                s_nxt.op_cnt    = 4'h0;
                s_nxt.dma_event = 1'b1;
                s_nxt.buf_half  = s_r.ctrl_two[`F_SPLIT_BUF] ? !s_r.buf_half : 1'b0;
            end
            else
            begin
                s_nxt.op_cnt = s_r.op_cnt + 4'h1;
            end
            s_nxt.set_b = s_r.ctrl_two[`F_ALT_INPUT] ? !s_r.set_b : 1'b0;
            if (scan_on)
            begin
                s_nxt.scan_idx = next_scan(s_r.scan_list, s_r.scan_idx);
            end
        end
        if (!s_r.ctrl_two[`F_SPLIT_BUF])
        begin
            s_nxt.buf_half = 1'b0;
        end
        if (!s_r.ctrl_two[`F_ALT_INPUT])
        begin
            s_nxt.set_b = 1'b0;
        end
        if (!running)
        begin
            s_nxt.op_cnt   = 4'h0;
            s_nxt.set_b    = 1'b0;
            s_nxt.buf_half = 1'b0;
        end

        // Registered outputs
        s_nxt.conv_tick    = tick;
        s_nxt.sampling     = running && (s_nxt.phase == PH_SAMPLE);
        s_nxt.vref_pos_ext = !ref_code[2] && ref_code[0];
        s_nxt.vref_neg_ext = !ref_code[2] && ref_code[1];
        s_nxt.chan_count   = chan_eff[1] ? 2'h3 : chan_eff;
        s_nxt.dma_words    = 8'h01 << s_r.ctrl_four[`F_DMA_LEN_HI:`F_DMA_LEN_LO];
        if (s_r.set_b)
        begin
            s_nxt.ch0_pos = s_r.main_sel[`F_MAIN_POS_B_HI:`F_MAIN_POS_B_LO];
            s_nxt.ch0_neg = s_r.main_sel[`F_MAIN_NEG_B];
            s_nxt.aux_pos = aux_eff[`F_AUX_POS_B];
            s_nxt.aux_neg = aux_eff[`F_AUX_NEG_B_HI:`F_AUX_NEG_B_LO];
        end
        else
        begin
            s_nxt.ch0_pos = scan_on ? s_r.scan_idx
                                    : s_r.main_sel[`F_MAIN_POS_A_HI:`F_MAIN_POS_A_LO];
            s_nxt.ch0_neg = s_r.main_sel[`F_MAIN_NEG_A];
            s_nxt.aux_pos = aux_eff[`F_AUX_POS_A];
            s_nxt.aux_neg = aux_eff[`F_AUX_NEG_A_HI:`F_AUX_NEG_A_LO];
        end
        if (s_nxt.aux_neg[1] == `NEG_SEL_VREF_HI)
        begin
            s_nxt.aux_neg = 2'h0;
        end
        if (SECOND_INSTANCE)
        begin
            s_nxt.ch0_pos[4] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r            <= '0;
            s_r.ctrl_two   <= `RST_REG16;
            s_r.ctrl_three <= `RST_REG16;
            s_r.ctrl_four  <= `RST_REG16;
            s_r.aux_sel    <= `RST_REG16;
            s_r.main_sel   <= `RST_REG16;
            s_r.mode       <= `RST_REG16;
            s_r.scan_list  <= `RST_SCAN;
            s_r.waitreq    <= 1'b1;
            s_r.phase      <= PH_SAMPLE;
            s_r.dma_words  <= 8'h01;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign readdata          = s_r.rdata;
    assign waitrequest       = s_r.waitreq;
    assign conv_tick         = s_r.conv_tick;
    assign start_conv        = s_r.start_conv;
    assign sampling          = s_r.sampling;
    assign dma_event         = s_r.dma_event;
    assign buffer_half_flag  = s_r.buf_half;
    assign ch0_pos_input     = s_r.ch0_pos;
    assign ch0_neg_input     = s_r.ch0_neg;
    assign aux_pos_input     = s_r.aux_pos;
    assign aux_neg_input     = s_r.aux_neg;
    assign vref_pos_external = s_r.vref_pos_ext;
    assign vref_neg_external = s_r.vref_neg_ext;
    assign channel_count     = s_r.chan_count;
    assign dma_buffer_words  = s_r.dma_words;

endmodule // adc_seq_ctrl

// file: tb/adc_seq_props.sv
`include "adc_seq_cfg.svh"
module adc_seq_props (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        conv_done_pin,
    input wire logic        start_conv,
    input wire logic        sampling,
    input wire logic        dma_event,
    input wire logic        buffer_half_flag,
    input wire logic [1:0]  aux_neg_input,
    input wire logic        vref_pos_external,
    input wire logic [7:0]  dma_buffer_words
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    logic wr_ok;
    assign wr_ok = write && !waitrequest;
    chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    chk_unmapped_zero: assert property (read && !waitrequest && address > 5'h18 |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_dma_words: assert property (wr_ok && address == `OFS_CTRL_FOUR && byteenable[0]
        |-> ##2 dma_buffer_words == 8'h1 << $past(writedata[2:0], 2))
        else $error("buffer words wrong");
    chk_ref_pos: assert property (wr_ok && address == `OFS_CTRL_TWO && byteenable[1]
        |-> ##2 vref_pos_external == (!$past(writedata[15], 2) && $past(writedata[13], 2)))
        else $error("positive reference wrong");
    chk_aux_code: assert property (aux_neg_input != 2'h1)
        else $error("aux negative code 01 shown");
    chk_start_pulse: assert property (start_conv |-> $past(sampling) ##[0:2] !sampling)
        else $error("start without sampling end");
    chk_start_once: assert property (start_conv |=> !start_conv)
        else $error("start pulse too long");
    chk_dma_cause: assert property (dma_event
        |-> ($past(conv_done_pin, 3) || $past(conv_done_pin, 4) || $past(conv_done_pin, 5))
        ##1 !dma_event)
        else $error("event without operation");
    chk_half_cause: assert property ($changed(buffer_half_flag)
        |-> dma_event || $past(dma_event) || $past(write) || $past(write, 2))
        else $error("buffer half moved alone");
    cover property (dma_event && buffer_half_flag);
    cover property (start_conv);
    cover property (wr_ok && address == `OFS_CTRL_FOUR);
endmodule // adc_seq_props

bind adc_seq_ctrl adc_seq_props u_props (.*);

// file: tb/adc_pins_model.sv
module adc_pins_model (
    input  wire logic sys_clk,
    input  wire logic rc_run,
    input  wire logic fire,
    output logic      rc_clk_pin,
    output logic      conv_done_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] rc_div = 2'h0;
    logic [1:0] hold   = 2'h0;
    logic       rc_lvl = 1'b0;
    // Oscillator stands still unless running
    always @(posedge sys_clk)
    begin
        rc_div <= rc_div + 2'h1;
        if (rc_run && rc_div == 2'h3)
            rc_lvl <= ~rc_lvl;
        if (fire)
            hold <= 2'h3;
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
    end
    // End of operation held three cycles
    assign conv_done_pin = hold != 2'h0;
    assign rc_clk_pin    = rc_lvl;
endmodule // adc_pins_model

// file: tb/adc_sequence_mux_config_tb_top.sv
`include "adc_seq_cfg.svh"
module adc_sequence_mux_config_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk    = 1'b0;
    logic        nrst       = 1'b0;
    logic [4:0]  address    = 5'h00;
    logic        read       = 1'b0;
    logic        write      = 1'b0;
    logic [31:0] writedata  = 32'h0;
    logic [3:0]  byteenable = 4'hf;
    logic        rc_run     = 1'b0;
    logic        fire       = 1'b0;
    logic [31:0] readdata, q;
    logic [4:0]  ch0_pos_input;
    logic [1:0]  aux_neg_input, channel_count;
    logic [7:0]  dma_buffer_words;
    logic        waitrequest, rc_clk_pin, conv_done_pin, conv_tick, start_conv, sampling;
    logic        dma_event, buffer_half_flag, ch0_neg_input, aux_pos_input;
    logic        vref_pos_external, vref_neg_external;
    int          failures = 0;
    int          comparisons = 0;
    int          ev_cnt, gap, last_gap, n_tick, samp_n, last_samp, n_start;

    initial forever #50 sys_clk = ~sys_clk;
    adc_seq_ctrl DUT (.*);
    adc_pins_model u_pins (.*);

    always @(posedge sys_clk)
    begin
        gap++;
        if (dma_event === 1'b1)
            ev_cnt++;
        if (conv_tick === 1'b1)
        begin
            last_gap = gap;
            gap = 0;
            n_tick++;
            if (sampling === 1'b1)
                samp_n++;
        end
        if (start_conv === 1'b1)
        begin
            last_samp = samp_n;
            samp_n = 0;
            n_start++;
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic rd_n, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        read <= rd_n;
        write <= !rd_n;
        address <= a;
        writedata <= d;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0)
        begin
            failures++;
            end_of_test();
        end
        else
        begin
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b1, a, 32'h0);
        check(q, e);
    endtask
    task automatic pulse();
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (9) @(posedge sys_clk);
    endtask

    task automatic t_regs();
        logic [15:0] m [5];
        m = '{16'he73f, 16'h9fff, 16'h0007, 16'h0707, 16'h9f9f};
        for (int i = 0; i < 7; i++)
            rd(5'(i * 4), 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            wr(5'(i * 4), 32'hffff_ffff);
            rd(5'(i * 4), {16'h0, m[i]});
        end
        wr(5'h1c, 32'hffff_ffff);
        rd(5'h1c, 32'h0);
        wr(`OFS_MODE, 32'h2);
        rd(`OFS_CTRL_TWO, 32'he43f);
        rd(`OFS_AUX_SEL, 32'h0);
        check(channel_count, 2'h0);
        wr(`OFS_MODE, 32'h0);
        rd(`OFS_AUX_SEL, 32'h0707);
    endtask

    task automatic t_fields();
        logic [2:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            wr(`OFS_CTRL_TWO, {16'h0, c, 3'h0, c[1:0], 8'h0});
            wr(`OFS_CTRL_FOUR, {29'h0, c});
            wr(`OFS_AUX_SEL, {29'h0, c});
            wr(`OFS_MAIN_SEL, {24'h0, c[0], 2'h0, c, 2'h3});
            repeat (3) @(posedge sys_clk);
            check(vref_pos_external, !c[2] && c[0]);
            check(vref_neg_external, !c[2] && c[1]);
            check(channel_count, c[1] ? 2'h3 : c[1:0]);
            check(dma_buffer_words, 8'h1 << c);
            check(aux_pos_input, c[0]);
            check(aux_neg_input, c[2] ? c[2:1] : 2'h0);
            check(ch0_neg_input, c[0]);
            check(ch0_pos_input, {c, 2'h3});
        end
    endtask

    task automatic t_ops(input logic [3:0] k);
        wr(`OFS_MAIN_SEL, 32'h9405);
        wr(`OFS_AUX_SEL, 32'h0700);
        wr(`OFS_CTRL_TWO, {26'h0, k, 2'h3});
        wr(`OFS_MODE, 32'h1);
        ev_cnt = 0;
        for (int i = 1; i <= 2 * (k + 1); i++)
        begin
            pulse();
            check(ch0_pos_input, i[0] ? 5'h14 : 5'h05);
            check(aux_neg_input, i[0] ? 2'h3 : 2'h0);
            check(ev_cnt, i / (k + 1));
            check(buffer_half_flag, (i / (k + 1)) % 2);
        end
        wr(`OFS_CTRL_TWO, {26'h0, k, 2'h0});
        pulse();
        check(ch0_pos_input, 5'h05);
        check(buffer_half_flag, 1'b0);
        wr(`OFS_MODE, 32'h0);
    endtask

    task automatic t_scan();
        wr(`OFS_SCAN_LIST, 32'h0000_0104);
        wr(`OFS_CTRL_TWO, 32'h0400);
        wr(`OFS_MODE, 32'h1);
        pulse();
        check(ch0_pos_input, 5'h02);
        pulse();
        check(ch0_pos_input, 5'h08);
        pulse();
        check(ch0_pos_input, 5'h02);
        wr(`OFS_CTRL_TWO, 32'h0);
        @(posedge sys_clk);
        check(ch0_pos_input, 5'h05);
        wr(`OFS_MODE, 32'h0);
    endtask

    task automatic t_auto();
        int t;
        wr(`OFS_CTRL_THREE, 32'h0202);
        samp_n = 0;
        n_start = 0;
        wr(`OFS_MODE, 32'h1d);
        for (t = 0; n_start < 1 && t < 200; t++)
            @(posedge sys_clk);
        if (n_start < 1)
        begin
            failures++;
            end_of_test();
        end
        @(posedge sys_clk);
        check(n_start, 1);
        check(last_samp, 2);
        check(last_gap, 3);
        wr(`OFS_MODE, 32'h0);
        wr(`OFS_MODE, 32'h1);
        t = n_start;
        repeat (40) @(posedge sys_clk);
        check(n_start, t);
        wr(`OFS_CTRL_THREE, 32'h8002);
        repeat (3) @(posedge sys_clk);
        t = n_tick;
        repeat (40) @(posedge sys_clk);
        check(n_tick, t);
        rc_run <= 1'b1;
        repeat (40) @(posedge sys_clk);
        check(last_gap, 8);
        wr(`OFS_MODE, 32'h0);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        check(dma_buffer_words, 8'h1);
        t_regs();
        t_fields();
        t_ops(4'h0);
        t_ops(4'h2);
        t_ops(4'hf);
        t_scan();
        t_auto();
        end_of_test();
    end
endmodule // adc_sequence_mux_config_tb_top
